// ===== common/rpd_pkg.sv
// shared constants and types for the signal-strength peak readout
package rpd_pkg;

  // ==========================================================
  // register map (byte addresses on the serial port)
  localparam logic [7:0] ADDR_TRIM  = 8'h1C;
  localparam logic [7:0] ADDR_CFG_A = 8'h6C;
  localparam logic [7:0] ADDR_CFG_B = 8'h8C;
  localparam logic [7:0] ADDR_TPEAK = 8'hAC;
  localparam logic [7:0] ADDR_RPEAK = 8'hAD;

  // ==========================================================
  // reset values
  localparam logic [7:0] TRIM_RST = 8'h15;
  localparam logic [7:0] CFG_RST  = 8'h00;
  localparam logic [7:0] PEAK_RST = 8'h00;
  localparam logic [7:0] UNMAPPED = 8'h00;

  // ==========================================================
  // field positions
  localparam int MON_SEL_MSB = 6;
  localparam int MON_SEL_LSB = 5;
  localparam int MON_BUF_BIT = 4;
  localparam int OFFS_MSB    = 3;
  localparam int OFFS_LSB    = 0;
  localparam int AAF_MSB     = 2;
  localparam int AAF_LSB     = 1;
  localparam int INV_BIT     = 0;

  // ==========================================================
  // serial frame: command byte, address byte, data byte, msb first
  localparam logic [7:0] CMD_WRITE  = 8'h02;
  localparam logic [7:0] CMD_READ   = 8'h03;
  localparam logic [4:0] ADDR_BITS  = 5'h10;
  localparam logic [4:0] FRAME_BITS = 5'h18;

  // ==========================================================
  // averaging: four samples per block
  localparam int AVG_LOG2 = 2;

  // ==========================================================
  // enumerations
  typedef enum logic [1:0] {
    MON_LIVE   = 2'b00,
    MON_OFFSET = 2'b01,
    MON_REF_HI = 2'b10,
    MON_REF_LO = 2'b11
  } rpd_mon_sel_t;

  typedef enum logic [1:0] {
    AAF_40K0 = 2'b00,
    AAF_13K6 = 2'b01,
    AAF_5K0  = 2'b10,
    AAF_3K6  = 2'b11
  } rpd_corner_t;

  typedef enum logic [1:0] {
    TG_IDLE  = 2'b00,
    TG_DELAY = 2'b01,
    TG_TRACK = 2'b11
  } rpd_tg_state_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    rpd_mon_sel_t monitor_select;
    logic         monitor_buffer_enable;
    logic [3:0]   offset_trim;
  } rpd_trim_t;

  typedef struct packed {
    rpd_corner_t antialias_corner;
    logic        code_polarity_invert;
  } rpd_rxcfg_t;

endpackage

// ===== rtl/rpd_avg4.sv
// block averager: mean of four consecutive converter samples
`timescale 1ns/10ps
module rpd_avg4
  import rpd_pkg::*;
#(
  parameter int DW = 8
)(
  // clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_n_i,
  // raw samples
  input  wire logic [DW-1:0] smp_i,
  input  wire logic          smp_vld_i,
  // averaged samples
  output logic      [DW-1:0] avg_o,
  output logic               avg_vld_o
);

  localparam int SW = DW + AVG_LOG2;

  if (DW < 1 || DW > 16)
    $error("rpd_avg4: DW out of range");

  logic [AVG_LOG2-1:0] cnt_r, cnt_nxt;
  logic [SW-1:0]       sum_r, sum_nxt, sum_full;
  logic [DW-1:0]       avg_r, avg_nxt;
  logic                vld_r, vld_nxt;

  // ==========================================================
  // non-overlapping blocks: the sum restarts after each output
  always_comb
  begin
    sum_full = sum_r + SW'(smp_i);
    cnt_nxt  = cnt_r;
    sum_nxt  = sum_r;
    avg_nxt  = avg_r;
    vld_nxt  = 1'b0;
    if (smp_vld_i)
    begin
      cnt_nxt = cnt_r + 1'b1;
      if (&cnt_r)
      begin
        avg_nxt = sum_full[SW-1:AVG_LOG2]; // RULE_07 RULE_20
        vld_nxt = 1'b1;
        sum_nxt = '0;
      end
      else
      begin
        sum_nxt = sum_full;
      end
    end
  end

  // registers only
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r <= '0;
      sum_r <= '0;
      avg_r <= '0;
      vld_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      sum_r <= sum_nxt;
      avg_r <= avg_nxt;
      vld_r <= vld_nxt;
    end
  end

  assign avg_o     = avg_r;
  assign avg_vld_o = vld_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_avg_block_mean: assert property ( // RULE_07
    (smp_vld_i && &cnt_r) |=> avg_vld_o && avg_o == $past(sum_full[SW-1:AVG_LOG2]))
    else $error("average not delivered at end of block");

  a_avg_only_block: assert property ( // RULE_20
    !(smp_vld_i && &cnt_r) |=> !avg_vld_o)
    else $error("average delivered mid-block");

endmodule // rpd_avg4

// ===== rtl/rpd_peak_top.sv
// signal-strength peak readout: trim/monitor registers, two peak detectors, serial port
//
// Contract
// [RULE_01] monitor select picks pin signal
// [RULE_02] trim bit 4 enables monitor buffer
// [RULE_03] offset trim code 0h min, Fh max
// [RULE_04] anti-alias field selects filter corner
// [RULE_05] config bit 0 inverts code polarity
// [RULE_06] 8-bit normalised strength samples accepted
// [RULE_07] detectors see four-sample averages
// [RULE_08] frame sync clears telegram peak, tracking
// [RULE_09] tracking start delayed by bit count
// [RULE_10] end of message copies telegram peak
// [RULE_11] telegram peak cleared only at reset
// [RULE_12] running detector observes while receiver runs
// [RULE_13] running peak rises on larger sample
// [RULE_14] read while running restarts running detector
// [RULE_15] read while stopped leaves detector alone
// [RULE_16] running peak resets to zero
// [RULE_17] host reads eleven times, averages ten
// [RULE_18] host trims offset with rf off
// [RULE_19] host trims gain at strong input
// [RULE_20] averages use disjoint four-sample blocks
`timescale 1ns/10ps
module rpd_peak_top
  import rpd_pkg::*;
#(
  parameter int POS_W = 4
)(
  // clock and reset
  input  wire logic             MCLK_I,
  input  wire logic             RSTN_I,
  // serial register port
  input  wire logic             SPI_CS_N_I,
  input  wire logic             SPI_SCK_I,
  input  wire logic             SPI_MOSI_I,
  output logic                  SPI_MISO_O,
  output logic                  SPI_MISO_OE_O,
  // converter samples and receiver events
  input  wire logic [7:0]       STRENGTH_SAMPLE_I,
  input  wire logic             STRENGTH_VALID_I,
  input  wire logic             RX_RUN_I,
  input  wire logic             FRAME_SYNC_EVENT_I,
  input  wire logic             END_OF_MESSAGE_EVENT_I,
  input  wire logic             DATA_BIT_TICK_I,
  input  wire logic [POS_W-1:0] PEAK_START_BIT_POSITION_I,
  // analog control outputs
  output rpd_trim_t             TRIM_MONITOR_O,
  output rpd_rxcfg_t            RX_CFG_A_O,
  output rpd_rxcfg_t            RX_CFG_B_O
);

  if (POS_W < 1 || POS_W > 8)
    $error("rpd_peak_top: POS_W out of range");

  // ==========================================================
  // serial port state
  logic        sck_q_r, sck_q_nxt;
  logic [4:0]  bit_r, bit_nxt;
  logic [23:0] shin_r, shin_nxt;
  logic [7:0]  tx_r, tx_nxt;
  logic        sck_rise, sck_fall;
  logic        addr_done, frame_done;
  logic [7:0]  hdr_cmd, hdr_addr, fr_cmd, fr_addr, fr_data;
  logic        wr_fire, rd_fire;
  logic [7:0]  rd_data;

  // edges of the serial clock; pins count as synchronous, one delay suffices
  assign sck_rise   = SPI_SCK_I & ~sck_q_r;
  assign sck_fall   = ~SPI_SCK_I & sck_q_r;
  assign hdr_cmd    = shin_r[14:7];
  assign hdr_addr   = {shin_r[6:0], SPI_MOSI_I};
  assign fr_cmd     = shin_r[22:15];
  assign fr_addr    = shin_r[14:7];
  assign fr_data    = {shin_r[6:0], SPI_MOSI_I};
  assign addr_done  = !SPI_CS_N_I && sck_rise && (bit_r == ADDR_BITS - 5'h01);
  assign frame_done = !SPI_CS_N_I && sck_rise && (bit_r == FRAME_BITS - 5'h01);
  assign wr_fire    = frame_done && fr_cmd == CMD_WRITE;
  assign rd_fire    = addr_done && hdr_cmd == CMD_READ;

  // shift in on rising edges, shift out on falling edges (mode 0)
  always_comb
  begin
    sck_q_nxt = SPI_SCK_I;
    bit_nxt   = bit_r;
    shin_nxt  = shin_r;
    tx_nxt    = tx_r;
    if (SPI_CS_N_I)
    begin
      bit_nxt = '0;
      tx_nxt  = '0;
    end
    else
    begin
      if (sck_rise)
      begin
        shin_nxt = {shin_r[22:0], SPI_MOSI_I};
        bit_nxt  = frame_done ? 5'h00 : bit_r + 5'h01;
      end
      if (rd_fire)
        tx_nxt = rd_data;
      else if (sck_fall && bit_r > ADDR_BITS)
        tx_nxt = {tx_r[6:0], 1'b0};
    end
  end

  // registers only
  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      sck_q_r <= 1'b0;
      bit_r   <= '0;
      shin_r  <= '0;
      tx_r    <= '0;
    end
    else
    begin
      sck_q_r <= sck_q_nxt;
      bit_r   <= bit_nxt;
      shin_r  <= shin_nxt;
      tx_r    <= tx_nxt;
    end
  end

  assign SPI_MISO_O    = tx_r[7];
  assign SPI_MISO_OE_O = ~SPI_CS_N_I; // drive only while selected

  // ==========================================================
  // write-only control registers
  rpd_trim_t  trim_r, trim_nxt;
  rpd_rxcfg_t cfg_a_r, cfg_a_nxt;
  rpd_rxcfg_t cfg_b_r, cfg_b_nxt;

  // reserved bits are dropped; writes elsewhere are ignored
  always_comb
  begin
    trim_nxt  = trim_r;
    cfg_a_nxt = cfg_a_r;
    cfg_b_nxt = cfg_b_r;
    if (wr_fire)
    begin
      unique case (fr_addr)
        ADDR_TRIM:
        begin
          trim_nxt.monitor_select        = rpd_mon_sel_t'(fr_data[MON_SEL_MSB:MON_SEL_LSB]); // RULE_01
          trim_nxt.monitor_buffer_enable = fr_data[MON_BUF_BIT]; // RULE_02
          trim_nxt.offset_trim           = fr_data[OFFS_MSB:OFFS_LSB]; // RULE_03
        end
        ADDR_CFG_A:
        begin
          cfg_a_nxt.antialias_corner     = rpd_corner_t'(fr_data[AAF_MSB:AAF_LSB]); // RULE_04
          cfg_a_nxt.code_polarity_invert = fr_data[INV_BIT]; // RULE_05
        end
        ADDR_CFG_B:
        begin
          cfg_b_nxt.antialias_corner     = rpd_corner_t'(fr_data[AAF_MSB:AAF_LSB]); // RULE_04
          cfg_b_nxt.code_polarity_invert = fr_data[INV_BIT]; // RULE_05
        end
        default: ;
      endcase
    end
  end

  // registers only
  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      trim_r  <= rpd_trim_t'(TRIM_RST[6:0]);
      cfg_a_r <= rpd_rxcfg_t'(CFG_RST[2:0]);
      cfg_b_r <= rpd_rxcfg_t'(CFG_RST[2:0]);
    end
    else
    begin
      trim_r  <= trim_nxt;
      cfg_a_r <= cfg_a_nxt;
      cfg_b_r <= cfg_b_nxt;
    end
  end

  assign TRIM_MONITOR_O = trim_r;
  assign RX_CFG_A_O     = cfg_a_r;
  assign RX_CFG_B_O     = cfg_b_r;

  // ==========================================================
  // averaged strength stream shared by both detectors
  logic [7:0] avg;
  logic       avg_vld;

  // samples arrive already normalised from the differential converter
  rpd_avg4 #(
    .DW (8)
  ) u_avg (
    .clk_i     (MCLK_I),
    .rst_n_i   (RSTN_I),
    .smp_i     (STRENGTH_SAMPLE_I), // RULE_06
    .smp_vld_i (STRENGTH_VALID_I),
    .avg_o     (avg),
    .avg_vld_o (avg_vld)
  );

  // ==========================================================
  // telegram peak detector
  rpd_tg_state_t    tg_st_r, tg_st_nxt;
  logic [POS_W-1:0] tg_cnt_r, tg_cnt_nxt;
  logic [7:0]       tg_int_r, tg_int_nxt;
  logic [7:0]       tg_peak_r, tg_peak_nxt;

  // end of message is taken before a coincident frame sync, so back-to-back
  // telegrams never lose the finished peak
  always_comb
  begin
    tg_st_nxt   = tg_st_r;
    tg_cnt_nxt  = tg_cnt_r;
    tg_int_nxt  = tg_int_r;
    tg_peak_nxt = tg_peak_r;
    unique case (tg_st_r)
      TG_IDLE: ;
      TG_DELAY:
      begin
        if (DATA_BIT_TICK_I)
        begin
          tg_cnt_nxt = tg_cnt_r - 1'b1;
          if (tg_cnt_r == POS_W'(1))
            tg_st_nxt = TG_TRACK; // RULE_09
        end
      end
      TG_TRACK:
      begin
        if (avg_vld && avg > tg_int_r)
          tg_int_nxt = avg;
      end
    endcase
    if (END_OF_MESSAGE_EVENT_I && tg_st_r != TG_IDLE)
    begin
      tg_peak_nxt = (tg_st_r == TG_TRACK && avg_vld && avg > tg_int_r) ? avg : tg_int_r; // RULE_10
      tg_st_nxt   = TG_IDLE;
    end
    if (FRAME_SYNC_EVENT_I)
    begin
      tg_int_nxt = '0; // RULE_08
      tg_cnt_nxt = PEAK_START_BIT_POSITION_I;
      tg_st_nxt  = (PEAK_START_BIT_POSITION_I == '0) ? TG_TRACK : TG_DELAY; // RULE_09
    end
  end

  // registers only; the readable peak is cleared by reset alone
  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      tg_st_r   <= TG_IDLE;
      tg_cnt_r  <= '0;
      tg_int_r  <= '0;
      tg_peak_r <= PEAK_RST; // RULE_11
    end
    else
    begin
      tg_st_r   <= tg_st_nxt;
      tg_cnt_r  <= tg_cnt_nxt;
      tg_int_r  <= tg_int_nxt;
      tg_peak_r <= tg_peak_nxt;
    end
  end

  // ==========================================================
  // free-running peak detector
  logic [7:0] rp_r, rp_nxt, rp_base;
  logic       rp_restart;

  // a read while running restarts from zero, but a sample landing in the
  // same cycle still counts, so the current level is never lost
  assign rp_restart = rd_fire && hdr_addr == ADDR_RPEAK && RX_RUN_I; // RULE_14 RULE_15

  always_comb
  begin
    rp_base = rp_restart ? 8'h00 : rp_r; // RULE_14
    rp_nxt  = rp_base;
    if (RX_RUN_I && avg_vld && avg > rp_base) // RULE_12
      rp_nxt = avg; // RULE_13
  end

  // registers only
  always_ff @(posedge MCLK_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      rp_r <= PEAK_RST; // RULE_16
    else
      rp_r <= rp_nxt;
  end

  // ==========================================================
  // read mux; write-only and unmapped addresses read as zero
  always_comb
  begin
    unique case (hdr_addr)
      ADDR_TPEAK: rd_data = tg_peak_r;
      ADDR_RPEAK: rd_data = rp_r;
      default:    rd_data = UNMAPPED;
    endcase
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RSTN_I);

  a_trim_monitor_sel: assert property ( // RULE_01
    (wr_fire && fr_addr == ADDR_TRIM)
      |=> TRIM_MONITOR_O.monitor_select == $past(fr_data[MON_SEL_MSB:MON_SEL_LSB]))
    else $error("monitor select not taken from write");

  a_trim_buffer_en: assert property ( // RULE_02
    (wr_fire && fr_addr == ADDR_TRIM)
      |=> TRIM_MONITOR_O.monitor_buffer_enable == $past(fr_data[MON_BUF_BIT]))
    else $error("buffer enable not taken from write");

  a_trim_offset_code: assert property ( // RULE_03
    (wr_fire && fr_addr == ADDR_TRIM)
      |=> TRIM_MONITOR_O.offset_trim == $past(fr_data[OFFS_MSB:OFFS_LSB]))
    else $error("offset trim not taken from write");

  a_cfg_a_corner: assert property ( // RULE_04
    (wr_fire && fr_addr == ADDR_CFG_A)
      |=> RX_CFG_A_O.antialias_corner == $past(fr_data[AAF_MSB:AAF_LSB]))
    else $error("corner not taken from write");

  a_cfg_b_invert: assert property ( // RULE_05
    (wr_fire && fr_addr == ADDR_CFG_B)
      |=> RX_CFG_B_O.code_polarity_invert == $past(fr_data[INV_BIT]))
    else $error("polarity invert not taken from write");

  a_sync_clears_int: assert property ( // RULE_08
    FRAME_SYNC_EVENT_I |=> tg_int_r == 8'h00)
    else $error("frame sync did not clear telegram peak");

  sequence s_delayed_start;
    FRAME_SYNC_EVENT_I && PEAK_START_BIT_POSITION_I != '0;
  endsequence

  a_sync_delays: assert property ( // RULE_09
    s_delayed_start |=> tg_st_r == TG_DELAY && tg_int_r == 8'h00)
    else $error("tracking not postponed after frame sync");

  a_eom_copies: assert property ( // RULE_10
    (END_OF_MESSAGE_EVENT_I && tg_st_r != TG_IDLE && !avg_vld)
      |=> tg_peak_r == $past(tg_int_r))
    else $error("end of message did not copy peak");

  a_peak_holds: assert property ( // RULE_11
    !END_OF_MESSAGE_EVENT_I |=> $stable(tg_peak_r))
    else $error("telegram peak changed without end of message");

  a_run_rises: assert property ( // RULE_13
    (RX_RUN_I && avg_vld && !rp_restart && avg > rp_r) |=> rp_r == $past(avg))
    else $error("running peak missed a higher sample");

  a_read_restart: assert property ( // RULE_14
    (rp_restart && !avg_vld) |=> rp_r == 8'h00)
    else $error("read while running did not restart detector");

  a_stopped_hold: assert property ( // RULE_15
    !RX_RUN_I |=> rp_r == $past(rp_r))
    else $error("running peak changed while receiver stopped");

endmodule // rpd_peak_top

// ===== verification/live_strength_signal_peak_detector_test.sv
// self-checking bench for the signal-strength peak readout
`timescale 1ns/10ps
module live_strength_signal_peak_detector_test;
  import rpd_pkg::*;

  // ==========================================================
  // design connections and bench model state
  logic       clk, rst_n, sck, cs_n, mosi, miso, miso_oe;
  logic       smp_vld, rx_run, frame_sync_event, end_of_message_event, tick, trk;
  logic [7:0] smp, seed, rp, tp, tp_int, v, w, r;
  logic [3:0] pos;
  logic [11:0] acc;
  rpd_trim_t  trim;
  rpd_rxcfg_t cfg_a, cfg_b;
  int         n_fail, check_count, i;

  rpd_peak_top #(.POS_W(4)) rpd_peak_top_i (
    .MCLK_I(clk), .RSTN_I(rst_n), .SPI_CS_N_I(cs_n), .SPI_SCK_I(sck),
    .SPI_MOSI_I(mosi), .SPI_MISO_O(miso), .SPI_MISO_OE_O(miso_oe),
    .STRENGTH_SAMPLE_I(smp), .STRENGTH_VALID_I(smp_vld), .RX_RUN_I(rx_run),
    .FRAME_SYNC_EVENT_I(frame_sync_event), .END_OF_MESSAGE_EVENT_I(end_of_message_event), .DATA_BIT_TICK_I(tick),
    .PEAK_START_BIT_POSITION_I(pos), .TRIM_MONITOR_O(trim), .RX_CFG_A_O(cfg_a),
    .RX_CFG_B_O(cfg_b)
  );

  rpd_host_model rpd_host_model_i (
    .clk_i(clk), .sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso),
    .miso_oe_i(miso_oe)
  );

  // ==========================================================
  // clock, 4 ns period
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================================
  // helpers: random source, comparison, register access
  function automatic logic [7:0] rnd();
    seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
    return seed;
  endfunction

  function automatic logic [31:0] rnd4();
    return {rnd(), rnd(), rnd(), rnd()};
  endfunction

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    rpd_host_model_i.frame({CMD_WRITE, a, d}, 24, v);
  endtask

  task automatic rd(input logic [7:0] a);
    rpd_host_model_i.frame({CMD_READ, a, 8'h00}, 24, v);
  endtask

  // a read while running restarts the bench's running peak too
  task automatic rdp(input string what);
    rd(ADDR_RPEAK);
    chk(what, v, rp);
    if (rx_run)
      rp = 8'h00;
  endtask

  // ==========================================================
  // receiver events: 0 frame sync, 1 end of message, other bit tick
  task automatic evt(input int which, input int n);
    repeat (n)
    begin
      case (which)
        0: frame_sync_event = 1'b1;
        1: end_of_message_event = 1'b1;
        default: tick = 1'b1;
      endcase
      @(negedge clk);
      {frame_sync_event, end_of_message_event, tick} = 3'b000;
      @(negedge clk);
    end
  endtask

  // one block of four samples, low byte first; the bench keeps both peaks
  task automatic blk(input logic [31:0] s);
    logic [9:0] sum;
    int         k;
    sum = 10'h000;
    for (k = 0; k < 4; k++)
    begin
      smp = s[8*k +: 8];
      smp_vld = 1'b1;
      sum = sum + {2'b00, s[8*k +: 8]};
      @(negedge clk);
      smp_vld = 1'b0;
      @(negedge clk);
    end
    if (rx_run && sum[9:2] > rp)
      rp = sum[9:2];
    if (trk && sum[9:2] > tp_int)
      tp_int = sum[9:2];
    repeat (3) @(negedge clk);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // hang guard: far beyond the length of the whole sequence
  initial
  begin
    repeat (60000) @(posedge clk);
    $display("ERROR watchdog expected finish seen timeout");
    n_fail++;
    stop_test();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    {smp, smp_vld, rx_run, frame_sync_event, end_of_message_event, tick, trk} = '0;
    {rp, tp, tp_int, v, w, r} = '0;
    pos = 4'h0;
    seed = 8'h4A;
    n_fail = 0;
    check_count = 0;
    rst_n = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    chk("trim_rst", {1'b0, trim}, TRIM_RST);
    chk("cfg_rst", {2'b00, cfg_a, cfg_b}, CFG_RST);
    rd(ADDR_TPEAK);
    chk("tpeak_rst", v, PEAK_RST);
    // every monitor select and corner code, offset at both ends
    for (i = 0; i < 4; i++)
    begin
      r = rnd();
      w = {1'b0, i[1:0], r[4], (i == 0) ? 4'h0 : (i == 3) ? 4'hF : r[3:0]};
      wr(ADDR_TRIM, w);
      chk("trim", {1'b0, trim}, w);
      w = {r[7:3], i[1:0], r[0]};
      wr(ADDR_CFG_A, w);
      chk("cfg_a", {5'h00, cfg_a}, {5'h00, w[2:0]});
      wr(ADDR_CFG_B, ~w);
      chk("cfg_b", {5'h00, cfg_b}, {5'h00, ~w[2:0]});
    end
    // refused traffic leaves the settings alone
    w = {1'b0, trim};
    rpd_host_model_i.frame({8'h07, ADDR_TRIM, 8'h00}, 24, v);
    rpd_host_model_i.frame({CMD_WRITE, ADDR_TRIM, 8'h00}, 20, v);
    wr(8'h55, 8'h00);
    chk("trim_kept", {1'b0, trim}, w);
    rd(ADDR_TRIM);
    chk("write_only", v, UNMAPPED);
    wr(ADDR_TPEAK, 8'hFF);
    rd(ADDR_TPEAK);
    chk("tpeak_ro", v, PEAK_RST);
    // telegram tracked from frame sync at once
    evt(0, 1);
    trk = 1'b1;
    repeat (3) blk(rnd4());
    evt(1, 1);
    tp = tp_int;
    trk = 1'b0;
    rd(ADDR_TPEAK);
    chk("tpeak", v, tp);
    // delayed start: strong blocks before the third bit are ignored
    pos = 4'h3;
    evt(0, 1);
    tp_int = 8'h00;
    blk(32'hFFFFFFFF);
    evt(2, 2);
    blk(32'hFFFFFFFF);
    evt(2, 1);
    trk = 1'b1;
    blk(rnd4() & 32'h7F7F7F7F);
    evt(1, 1);
    tp = tp_int;
    trk = 1'b0;
    rd(ADDR_TPEAK);
    chk("tpeak_delay", v, tp);
    // stray end of message, then an open telegram: register holds
    evt(1, 1);
    pos = 4'h0;
    evt(0, 1);
    trk = 1'b1;
    tp_int = 8'h00;
    blk(32'hFFFFFFFF);
    rd(ADDR_TPEAK);
    chk("tpeak_hold", v, tp);
    evt(1, 1);
    trk = 1'b0;
    rd(ADDR_TPEAK);
    chk("tpeak_late", v, tp_int);
    // running detector
    rx_run = 1'b1;
    rdp("rpeak_rst");
    blk(32'hFF000000);
    blk(32'h00FFFFFF);
    rdp("disjoint");
    for (i = 0; i < 6; i++)
    begin
      repeat (1 + rnd() % 3) blk(rnd4());
      rdp("running");
    end
    blk(32'h40404040);
    rx_run = 1'b0;
    blk(32'hFFFFFFFF);
    rdp("stopped");
    rdp("stopped_again");
    rx_run = 1'b1;
    rdp("resume");
    rdp("restarted");
    // host trim pass: no signal, then strong input; eleven running-peak reads
    // each, first dropped, last ten summed; read spacing shortened for run time
    wr(ADDR_TRIM, 8'h10);
    chk("trim_min", {1'b0, trim}, 8'h10);
    for (i = 0; i < 22; i++)
    begin
      w = (i < 11) ? 8'h02 + 8'(rnd() % 4) : 8'hFC + 8'(rnd() % 3);
      blk({4{w}});
      rdp("trim_read");
      acc = (i % 11 == 0) ? 12'h000 : acc + {4'h0, v};
      r = (i < 11) ? {7'h00, (acc >= 12'h014 && acc <= 12'h032)}
                   : {7'h00, (acc >= 12'h9D8 && acc <= 12'h9EC)};
      if (i % 11 == 10)
        chk("trim_band", r, 8'h01);
    end
    stop_test();
  end
endmodule // live_strength_signal_peak_detector_test

// ===== verification/rpd_host_model.sv
// host-side serial master model for the peak readout register port
`timescale 1ns/10ps
module rpd_host_model
  import rpd_pkg::*;
(
  // pacing clock
  input  wire logic clk_i,
  // serial port
  output logic      sck_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i,
  input  wire logic miso_oe_i
);
  // ==========================================================
  // idle: serial clock parked low, device not selected
  initial
  begin
    sck_o  = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  // ==========================================================
  // one frame, msb first, cut short after nbits bits; four system clocks per
  // half period leaves room for a synchroniser in front of the edge detect
  task automatic frame(input logic [23:0] word, input int nbits, output logic [7:0] rdat);
    int i;
    rdat = 8'h00;
    @(negedge clk_i);
    cs_n_o = 1'b0;
    for (i = 23; i > 23 - nbits; i--)
    begin
      mosi_o = word[i];
      repeat (4) @(negedge clk_i);
      if (i < 8)
        rdat[i] = miso_oe_i ? miso_i : 1'b1;  // take bit just before the rise
      sck_o = 1'b1;
      repeat (4) @(negedge clk_i);
      sck_o = 1'b0;
    end
    repeat (4) @(negedge clk_i);
    cs_n_o = 1'b1;
    mosi_o = ~mosi_o;  // released line shows the inverse, never a stale bit
    repeat (4) @(negedge clk_i);
  endtask
endmodule // rpd_host_model
